// ===== design/psmc_params.svh
/*
  Constants of the pin sense and mode control block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 200 MHz pclk and an APB master with 32-bit data.
*/
`ifndef PSMC_PARAMS_SVH
`define PSMC_PARAMS_SVH

`define PSMC_CLK_MHZ 200
`define PSMC_DEBOUNCE_US 32
`define PSMC_PROBE_PERIOD_US 1024
`define PSMC_POWERUP_MS 10
`define PSMC_LIN_BAUD 19200
`define PSMC_LIN_TIMEOUT_BITS 25000

`define PSMC_SLEEP_ID 8'h3c
`define PSMC_SLEEP_DATA 8'h00

`define PSMC_OFS_CTRL 12'h000
`define PSMC_OFS_STATUS 12'h004
`define PSMC_OFS_RESP 12'h008
`define PSMC_OFS_CHK 12'h00c

`define PSMC_CTRL_SWAP 0
`define PSMC_CTRL_FB_EN 1
`define PSMC_CTRL_CLR_SUPPLY 2
`define PSMC_ST_MODE 0
`define PSMC_ST_PIN 3
`define PSMC_ST_SW 5
`define PSMC_ST_SUPPLY 6
`define PSMC_ST_ADDR 8

`define PSMC_RST_SWAP 1'b0
`define PSMC_RST_FB_EN 1'b0

`endif

// ===== design/psmc_pkg.sv
/*
  Types of the pin sense and mode control block.
  Assumes the constants header is included by users of the widths.
*/
package psmc_pkg;

  typedef enum logic [2:0] {
    M_POWERUP, M_STANDBY, M_HALT, M_SLEEP, M_SHUTDOWN
  } psmc_mode_t;

  typedef enum logic [1:0] {P_FLOAT, P_LOW, P_HIGH} psmc_pin_t;

  typedef enum logic [1:0] {PH_IDLE, PH_LS, PH_HS} psmc_phase_t;

  typedef struct packed {
    logic step_loss;
    logic electrical_defect;
    logic undervoltage;
    logic thermal_shutdown;
    logic thermal_warning;
    logic [1:0] temp_info;
  } psmc_flags_t;

  typedef struct packed {
    logic [7:0] id;
    logic [7:0] data0;
  } psmc_frame_t;

  typedef struct packed {
    psmc_mode_t mode;
    psmc_mode_t halt_to;
    psmc_phase_t phase;
    logic [23:0] ptmr;
    logic [23:0] dtmr;
    logic [23:0] pu_tmr;
    psmc_pin_t addr;
    logic sw;
    logic [15:0] pos_snap;
    logic hs;
    logic ls;
    logic fallback_go;
    logic halt_go;
    logic [15:0] target_pos;
    logic target_load;
    logic bridge_hiz;
    logic sleep_out;
    logic rx_en;
    logic cmd_accept;
    logic supply_rst;
    logic swap;
    logic fb_en;
    logic [3:0] pa;
    logic [6:0] node_addr;
    logic [15:0] bit_div;
    logic [15:0] idle_bits;
    logic [31:0] resp;
    logic [7:0] chk;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } psmc_state_t;

endpackage

// ===== design/psmc_top.sv
/*
  Pin sense and mode control of a bus-attached stepper driver: probe
  sequencing of the tri-state address pin and the switch pin, the position
  reply, and power-up, halt, sleep, wake and thermal shutdown handling.
  Assumes a LIN handler that reports decoded frames and bus activity, a
  position controller that reports position and motion, and an APB master.
*/
`timescale 1ns/1ps
`include "psmc_params.svh"

module psmc_top #(
  parameter int unsigned DEBOUNCE_CYC = `PSMC_DEBOUNCE_US * `PSMC_CLK_MHZ,
  parameter int unsigned PERIOD_CYC =
    `PSMC_PROBE_PERIOD_US * `PSMC_CLK_MHZ,
  parameter int unsigned POWERUP_CYC =
    `PSMC_POWERUP_MS * 1000 * `PSMC_CLK_MHZ,
  parameter int unsigned BIT_CYC =
    (`PSMC_CLK_MHZ * 1000000) / `PSMC_LIN_BAUD,
  parameter int unsigned TIMEOUT_BITS = `PSMC_LIN_TIMEOUT_BITS
) (
  input wire logic pclk, // 200 MHz clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic probe_comparator_out, // address pin comparator
  input wire logic switch_comparator_out, // switch pin comparator
  input wire logic [1:0] hw_addr_pins, // two-state address pins
  input wire logic [3:0] programmed_addr_bits, // from programmed memory
  input wire logic otp_address_swap, // swap bit from programmed memory
  input wire logic otp_fallback_enable, // fallback enable from memory
  input wire logic [15:0] current_position, // from position controller
  input wire logic motion_active, // motor is moving
  input wire logic read_position_cmd, // pulse: build position reply
  input wire psmc_pkg::psmc_flags_t status_flags, // diagnostic flags
  input wire logic lin_frame_valid, // pulse: valid frame received
  input wire psmc_pkg::psmc_frame_t lin_frame, // frame id and byte 0
  input wire logic lin_activity, // dominant level seen on the bus
  output logic high_side_probe, // closes top switch
  output logic low_side_probe, // closes bottom switch
  output psmc_pkg::psmc_pin_t addr_pin_state, // Float, Low or High
  output logic switch_closed_flag, // external switch closed
  output logic [6:0] node_address, // assembled node address
  output logic goto_fallback, // pulse: move to fallback position
  output logic gentle_halt, // pulse: decelerate and stop
  output logic [15:0] target_position, // target after a halt
  output logic target_load, // pulse: load target position
  output logic bridge_hiz, // bridges in high impedance
  output logic sleep_mode, // everything but LIN receiver off
  output logic lin_rx_enable, // LIN receiver powered
  output logic cmd_accept // positioning commands allowed
);

  psmc_pkg::psmc_state_t st;
  psmc_pkg::psmc_state_t next_st;

  localparam logic [23:0] DEB_LAST = 24'(DEBOUNCE_CYC - 1);
  localparam logic [23:0] PER_LAST = 24'(PERIOD_CYC - 1);
  localparam logic [23:0] PER_HALF = 24'(PERIOD_CYC / 2);
  localparam logic [23:0] PU_LAST = 24'(POWERUP_CYC - 1);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] TO_BITS = 16'(TIMEOUT_BITS);

  logic sample_ls;
  logic sample_hs;
  logic sleep_frame;
  logic bit_tick;
  logic access;
  logic [7:0] byte1;
  logic [7:0] stat_byte;

  assign sample_ls = st.phase == psmc_pkg::PH_LS && st.dtmr == 24'h0;
  assign sample_hs = st.phase == psmc_pkg::PH_HS && st.dtmr == 24'h0;
  assign sleep_frame = lin_frame_valid &&
    lin_frame.id == `PSMC_SLEEP_ID && lin_frame.data0 == `PSMC_SLEEP_DATA;
  assign bit_tick = st.bit_div == BIT_LAST;
  assign access = psel && penable && st.pready;
  assign byte1 = {st.sw, st.node_addr};
  assign stat_byte = {st.supply_rst, status_flags};

  // Classic LIN sum: add with end-around carry, then invert.
  function automatic logic [7:0] lin_sum(input logic [31:0] d);
    logic [8:0] acc;
    acc = 9'h0;
    for (int i = 0; i < 4; i++) begin
      acc = {1'b0, acc[7:0]} + {1'b0, d[8*i +: 8]} + {8'h0, acc[8]};
    end
    acc = {1'b0, acc[7:0]} + {8'h0, acc[8]};
    // A sum of 9'h1ff folds to 9'h100, so one more fold is needed.
    acc = {1'b0, acc[7:0]} + {8'h0, acc[8]};
    return ~acc[7:0];
  endfunction

  always_comb begin
    next_st = st;
    next_st.fallback_go = 1'b0;
    next_st.halt_go = 1'b0;
    next_st.target_load = 1'b0;

    // Probe schedule: low side at the period start, high side at its
    // middle, so the two pulses can never overlap.
    next_st.ptmr = (st.ptmr == PER_LAST) ? 24'h0 : st.ptmr + 24'h1;
    case (st.phase)
      psmc_pkg::PH_IDLE: begin
        if (st.ptmr == 24'h0) begin
          next_st.phase = psmc_pkg::PH_LS;
          next_st.ls = 1'b1;
          next_st.dtmr = DEB_LAST;
        end else if (st.ptmr == PER_HALF) begin
          next_st.phase = psmc_pkg::PH_HS;
          next_st.hs = 1'b1;
          next_st.dtmr = DEB_LAST;
        end
      end
      psmc_pkg::PH_LS, psmc_pkg::PH_HS: begin
        // Comparator is only trusted once the debounce has run out.
        if (st.dtmr == 24'h0) begin
          next_st.phase = psmc_pkg::PH_IDLE;
          next_st.ls = 1'b0;
          next_st.hs = 1'b0;
        end else begin
          next_st.dtmr = st.dtmr - 24'h1;
        end
      end
      default: begin
        next_st.phase = psmc_pkg::PH_IDLE;
        next_st.ls = 1'b0;
        next_st.hs = 1'b0;
      end
    endcase

    if (sample_ls) begin
      if (probe_comparator_out) begin
        next_st.addr = psmc_pkg::P_HIGH;
      end else if (st.addr == psmc_pkg::P_HIGH) begin
        next_st.addr = psmc_pkg::P_FLOAT;
        next_st.fallback_go = 1'b1;
      end
    end
    if (sample_hs) begin
      if (probe_comparator_out) begin
        next_st.addr = psmc_pkg::P_LOW;
      end else if (st.addr == psmc_pkg::P_LOW) begin
        next_st.addr = psmc_pkg::P_FLOAT;
      end
    end
    if (sample_ls || sample_hs) begin
      next_st.sw = switch_comparator_out;
      next_st.pos_snap = current_position;
    end

    // Float reads as 0 in the assembled address.
    next_st.node_addr = st.swap ?
      {hw_addr_pins, st.addr == psmc_pkg::P_HIGH, st.pa} :
      {st.pa, hw_addr_pins, st.addr == psmc_pkg::P_HIGH};

    if (read_position_cmd) begin
      next_st.resp = {stat_byte, st.pos_snap[7:0], st.pos_snap[15:8],
        byte1};
      next_st.chk = lin_sum({stat_byte, st.pos_snap[7:0],
        st.pos_snap[15:8], byte1});
    end

    // Bus idle watch in bit slots.
    next_st.bit_div = bit_tick ? 16'h0 : st.bit_div + 16'h1;
    if (lin_activity || lin_frame_valid) begin
      next_st.idle_bits = 16'h0;
    end else if (bit_tick && st.idle_bits != TO_BITS) begin
      next_st.idle_bits = st.idle_bits + 16'h1;
    end

    case (st.mode)
      psmc_pkg::M_POWERUP: begin
        if (st.pu_tmr == PU_LAST) begin
          next_st.mode = psmc_pkg::M_STANDBY;
          next_st.pa = programmed_addr_bits;
          next_st.swap = otp_address_swap;
          next_st.fb_en = otp_fallback_enable;
          next_st.bridge_hiz = 1'b0;
        end else begin
          next_st.pu_tmr = st.pu_tmr + 24'h1;
        end
      end
      psmc_pkg::M_STANDBY: begin
        if (status_flags.thermal_shutdown) begin
          next_st.mode = psmc_pkg::M_HALT;
          next_st.halt_to = psmc_pkg::M_SHUTDOWN;
          next_st.halt_go = 1'b1;
        end else if (sleep_frame ||
            (bit_tick && st.idle_bits == TO_BITS)) begin
          next_st.mode = psmc_pkg::M_HALT;
          next_st.halt_to = psmc_pkg::M_SLEEP;
          if (motion_active && st.fb_en) begin
            next_st.fallback_go = 1'b1;
          end else if (motion_active) begin
            next_st.halt_go = 1'b1;
          end
        end
      end
      psmc_pkg::M_HALT: begin
        if (!motion_active) begin
          next_st.mode = st.halt_to;
          if (st.halt_to != psmc_pkg::M_STANDBY) begin
            next_st.bridge_hiz = 1'b1;
          end
          if (st.halt_to == psmc_pkg::M_SLEEP) begin
            next_st.sleep_out = 1'b1;
          end
          next_st.target_pos = current_position;
          next_st.target_load = 1'b1;
        end
      end
      psmc_pkg::M_SLEEP: begin
        if (lin_frame_valid) begin
          next_st.mode = psmc_pkg::M_STANDBY;
          next_st.sleep_out = 1'b0;
          next_st.bridge_hiz = 1'b0;
        end
      end
      psmc_pkg::M_SHUTDOWN: begin
        if (!status_flags.thermal_shutdown) begin
          next_st.mode = psmc_pkg::M_STANDBY;
          next_st.bridge_hiz = 1'b0;
        end
      end
      default: begin
        next_st.mode = psmc_pkg::M_STANDBY;
      end
    endcase
    next_st.cmd_accept = next_st.mode == psmc_pkg::M_STANDBY &&
      !status_flags.thermal_shutdown &&
      !status_flags.electrical_defect;

    // APB: one wait state, answer registered.
    next_st.pready = psel && penable && !st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0;
    if (psel && penable && !st.pready) begin
      case (paddr)
        `PSMC_OFS_CTRL: begin
          next_st.prdata[`PSMC_CTRL_SWAP] = st.swap;
          next_st.prdata[`PSMC_CTRL_FB_EN] = st.fb_en;
        end
        `PSMC_OFS_STATUS: begin
          next_st.prdata[`PSMC_ST_MODE +: 3] = st.mode;
          next_st.prdata[`PSMC_ST_PIN +: 2] = st.addr;
          next_st.prdata[`PSMC_ST_SW] = st.sw;
          next_st.prdata[`PSMC_ST_SUPPLY] = st.supply_rst;
          next_st.prdata[`PSMC_ST_ADDR +: 7] = st.node_addr;
        end
        `PSMC_OFS_RESP: next_st.prdata = st.resp;
        `PSMC_OFS_CHK: next_st.prdata = {24'h0, st.chk};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (access && pwrite && paddr == `PSMC_OFS_CTRL) begin
      next_st.swap = pwdata[`PSMC_CTRL_SWAP];
      next_st.fb_en = pwdata[`PSMC_CTRL_FB_EN];
      if (pwdata[`PSMC_CTRL_CLR_SUPPLY]) begin
        next_st.supply_rst = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mode <= psmc_pkg::M_POWERUP;
      st.halt_to <= psmc_pkg::M_STANDBY;
      st.phase <= psmc_pkg::PH_IDLE;
      st.addr <= psmc_pkg::P_FLOAT;
      st.sw <= 1'b0;
      st.bridge_hiz <= 1'b1;
      st.supply_rst <= 1'b1;
      st.rx_en <= 1'b1;
      st.swap <= `PSMC_RST_SWAP;
      st.fb_en <= `PSMC_RST_FB_EN;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign high_side_probe = st.hs;
  assign low_side_probe = st.ls;
  assign addr_pin_state = st.addr;
  assign switch_closed_flag = st.sw;
  assign node_address = st.node_addr;
  assign goto_fallback = st.fallback_go;
  assign gentle_halt = st.halt_go;
  assign target_position = st.target_pos;
  assign target_load = st.target_load;
  assign bridge_hiz = st.bridge_hiz;
  assign sleep_mode = st.sleep_out;
  assign lin_rx_enable = st.rx_en;
  assign cmd_accept = st.cmd_accept;

  a_probe_exclusive: assert property (
    @(posedge pclk) disable iff (!presetn) !(st.hs && st.ls))
    else $error("both probe switches closed");

  a_ls_sets_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    sample_ls && probe_comparator_out |=> st.addr == psmc_pkg::P_HIGH)
    else $error("low-side hit did not give High");

  a_high_to_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    sample_ls && !probe_comparator_out && st.addr == psmc_pkg::P_HIGH
    |=> st.addr == psmc_pkg::P_FLOAT && goto_fallback)
    else $error("lost High did not go Float with fallback");

  a_hs_sets_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    sample_hs && probe_comparator_out |=> st.addr == psmc_pkg::P_LOW)
    else $error("high-side hit did not give Low");

  a_hs_keeps_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    sample_hs && !probe_comparator_out && st.addr == psmc_pkg::P_HIGH
    |=> st.addr == psmc_pkg::P_HIGH)
    else $error("high-side miss disturbed High");

  a_pulse_min_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.ls) |-> st.ls [*8])
    else $error("probe pulse shorter than debounce");

  a_capture_pos: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sample_ls || sample_hs) |=> st.pos_snap == $past(current_position)
      && st.sw == $past(switch_comparator_out))
    else $error("switch and position not captured together");

  a_sleep_frame: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.mode == psmc_pkg::M_STANDBY && sleep_frame &&
    !status_flags.thermal_shutdown |=> st.mode == psmc_pkg::M_HALT)
    else $error("sleep frame ignored");

  a_wake_frame: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.mode == psmc_pkg::M_SLEEP && lin_frame_valid
    |=> st.mode == psmc_pkg::M_STANDBY && !sleep_mode)
    else $error("valid frame did not wake");

  a_halt_target: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.mode == psmc_pkg::M_HALT && !motion_active
    |=> target_load && target_position == $past(current_position))
    else $error("halt end did not load target");

  a_thermal_halt: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.mode == psmc_pkg::M_STANDBY && status_flags.thermal_shutdown
    |=> gentle_halt && st.halt_to == psmc_pkg::M_SHUTDOWN)
    else $error("thermal shutdown without halt");

  c_pin_high: cover property (
    @(posedge pclk) disable iff (!presetn) st.addr == psmc_pkg::P_HIGH);
  c_fallback: cover property (
    @(posedge pclk) disable iff (!presetn) goto_fallback);
  c_sleep: cover property (
    @(posedge pclk) disable iff (!presetn) st.mode == psmc_pkg::M_SLEEP);
  c_shutdown: cover property (
    @(posedge pclk) disable iff (!presetn)
    st.mode == psmc_pkg::M_SHUTDOWN);

endmodule

// ===== test/pin_sense_and_mode_control_bench.sv
/*
  Self-checking bench of the pin sense and mode control block.
  Assumes the design with shortened counts and the pin model beside it.
*/
`timescale 1ns/1ps

module pin_sense_and_mode_control_bench;
  localparam int DEB = 8;
  localparam int PER = 40;
  typedef struct packed {
    logic [1:0] c;
    logic s;
    psmc_pkg::psmc_pin_t st;
    logic [3:0] f;
  } psmc_row_t;
  psmc_row_t rows [6] = '{
    '{2'd2, 1'b1, psmc_pkg::P_HIGH, 4'd0},
    '{2'd0, 1'b0, psmc_pkg::P_FLOAT, 4'd1},
    '{2'd1, 1'b1, psmc_pkg::P_LOW, 4'd0},
    '{2'd2, 1'b0, psmc_pkg::P_HIGH, 4'd0},
    '{2'd1, 1'b0, psmc_pkg::P_LOW, 4'd1},
    '{2'd0, 1'b1, psmc_pkg::P_FLOAT, 4'd0}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, cmp, swc, hs, ls, swf, fbp, ghp, tlp;
  logic bhz, slp, rxe, acc, lsq = 1'b0, hsq = 1'b0, seen = 1'b0;
  logic [1:0] cond = 2'd0;
  logic [1:0] hwp = 2'b01;
  logic [3:0] pab = 4'ha;
  logic osw = 1'b0, ofb = 1'b0;
  logic sw_cl = 1'b0, mot = 1'b0, rdcmd = 1'b0, fval = 1'b0, act = 1'b1;
  logic [15:0] pos = 16'h1234, tpos;
  logic [6:0] nad;
  psmc_pkg::psmc_flags_t flags = 7'h56;
  psmc_pkg::psmc_frame_t frame = 16'h0000;
  psmc_pkg::psmc_pin_t pst;
  int n_errors = 0, tests_run = 0, n_fb = 0, n_gh = 0, n_tl = 0, pc = 0;

  psmc_top #(.DEBOUNCE_CYC(DEB), .PERIOD_CYC(PER), .POWERUP_CYC(10),
    .BIT_CYC(4), .TIMEOUT_BITS(5)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .probe_comparator_out(cmp), .switch_comparator_out(swc),
    .hw_addr_pins(hwp), .programmed_addr_bits(pab),
    .otp_address_swap(osw), .otp_fallback_enable(ofb),
    .current_position(pos), .motion_active(mot), .read_position_cmd(rdcmd),
    .status_flags(flags), .lin_frame_valid(fval), .lin_frame(frame),
    .lin_activity(act), .high_side_probe(hs), .low_side_probe(ls),
    .addr_pin_state(pst), .switch_closed_flag(swf), .node_address(nad),
    .goto_fallback(fbp), .gentle_halt(ghp), .target_position(tpos),
    .target_load(tlp), .bridge_hiz(bhz), .sleep_mode(slp),
    .lin_rx_enable(rxe), .cmd_accept(acc));

  psmc_pin_model pin_u (.pclk(pclk), .pin_cond(cond), .sw_closed(sw_cl),
    .high_side_probe(hs), .low_side_probe(ls),
    .probe_comparator_out(cmp), .switch_comparator_out(swc));

  always #2.5 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Probe timing is measured from the edges of the probe controls.
  always @(posedge pclk) begin
    lsq <= ls;
    hsq <= hs;
    pc <= pc + 1;
    n_fb <= n_fb + (fbp === 1'b1);
    n_gh <= n_gh + (ghp === 1'b1);
    n_tl <= n_tl + (tlp === 1'b1);
    if (ls === 1'b1 && hs === 1'b1) chk(0, 1, "probes overlap");
    if (!presetn || slp !== 1'b0) seen <= 1'b0;
    else if (ls && !lsq) begin
      if (seen) chk(pc, PER, "probe period");
      pc <= 1;
      seen <= 1'b1;
    end else if (seen && !ls && lsq) chk(pc, DEB, "width");
    else if (seen && hs && !hsq) chk(pc, PER / 2, "phase");
  end

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) chk(0, 1, "no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_sig(input bit hsel, input logic v);
    int k;
    k = 0;
    while ((hsel ? hs : ls) !== v && k < 100) begin
      @(posedge pclk);
      k++;
    end
  endtask

  task lin(input logic [15:0] f);
    @(posedge pclk);
    frame <= f;
    fval <= 1'b1;
    @(posedge pclk);
    fval <= 1'b0;
  endtask

  function automatic logic [7:0] csum(input logic [31:0] e);
    logic [8:0] s;
    s = 9'h0;
    for (int i = 0; i < 4; i++) begin
      s = {1'b0, s[7:0]} + e[8*i +: 8];
      s = {1'b0, s[7:0]} + s[8];
    end
    return ~s[7:0];
  endfunction

  task resp(input logic [15:0] p, input logic v);
    logic [31:0] e;
    e = {v, flags, p[7:0], p[15:8], sw_cl, pab, hwp, 1'b0};
    @(posedge pclk);
    rdcmd <= 1'b1;
    @(posedge pclk);
    rdcmd <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, e, "reply");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd[7:0], csum(e), "checksum");
  endtask

  initial begin
    int f0;
    int g0;
    cyc(6);
    chk(pst, psmc_pkg::P_FLOAT, "pin after reset");
    chk({swf, hs, ls, bhz, rxe}, 5'b00011, "reset outputs");
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    chk({bhz, acc}, 2'b10, "during power-up");
    cyc(15);
    chk({bhz, acc}, 2'b01, "standby");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'(psmc_pkg::M_STANDBY), "mode");
    for (int i = 0; i < 6; i++) begin
      wait_sig(1'b0, 1'b0);
      wait_sig(1'b0, 1'b1);
      f0 = n_fb;
      cond <= rows[i].c;
      sw_cl <= rows[i].s;
      wait_sig(1'b1, 1'b1);
      wait_sig(1'b1, 1'b0);
      cyc(2);
      chk(pst, rows[i].st, "pin state");
      chk(swf, rows[i].s, "switch flag");
      chk(n_fb - f0, rows[i].f, "fallback");
      chk(nad, {4'ha, 2'b01, rows[i].st == psmc_pkg::P_HIGH}, "addr");
    end
    apb(1'b1, 12'h000, 32'h1);
    cyc(3);
    chk(nad, {2'b01, 1'b0, 4'ha}, "swapped address");
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped"); 
    apb(1'b1, 12'h000, 32'h0);
    wait_sig(1'b0, 1'b0);
    wait_sig(1'b0, 1'b1);
    pos <= 16'h5678;
    resp(16'h1234, 1'b1);
    wait_sig(1'b0, 1'b0);
    cyc(2);
    apb(1'b1, 12'h000, 32'h4);
    resp(16'h5678, 1'b0);
    lin(16'h3c01);
    cyc(4);
    chk(slp, 1'b0, "other frame");
    f0 = n_tl;
    lin(16'h3c00);
    cyc(3);
    chk({slp, bhz, rxe}, 3'b111, "sleep");
    chk({tpos, 4'(n_tl - f0)}, {pos, 4'd1}, "target load");
    lin(16'h1255);
    cyc(3);
    chk(slp, 1'b0, "wake");
    for (int fb = 0; fb < 2; fb++) begin
      apb(1'b1, 12'h000, {30'h0, fb[0], 1'b0});
      mot <= 1'b1;
      f0 = n_fb;
      g0 = n_gh;
      lin(16'h3c00);
      cyc(3);
      chk({slp, 4'(n_fb - f0), 4'(n_gh - g0)}, {1'b0, 3'd0, fb[0], 3'd0,
        !fb[0]}, "sleep in motion");
      mot <= 1'b0;
      cyc(3);
      chk(slp, 1'b1, "asleep");
      lin(16'h0000);
      cyc(3);
    end
    act <= 1'b0;
    cyc(18);
    chk(slp, 1'b0, "idle early");
    cyc(22);
    chk(slp, 1'b1, "idle timeout");
    act <= 1'b1;
    lin(16'h0000);
    cyc(3);
    chk(slp, 1'b0, "wake after timeout");
    mot <= 1'b1;
    g0 = n_gh;
    flags.thermal_shutdown <= 1'b1;
    cyc(3);
    chk(n_gh - g0, 1, "thermal halt");
    mot <= 1'b0;
    cyc(3);
    apb(1'b0, 12'h004, 32'h0);
    chk({acc, rd[2:0]}, {1'b0, 3'(psmc_pkg::M_SHUTDOWN)}, "shut");
    flags.thermal_shutdown <= 1'b0;
    cyc(3);
    chk(acc, 1'b1, "recovered");
    osw <= 1'b1;
    ofb <= 1'b1;
    pab <= 4'h5;
    hwp <= 2'b10;
    presetn <= 1'b0;
    cyc(2);
    chk(bhz, 1'b1, "second reset");
    presetn <= 1'b1;
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    cyc(2);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[1:0], 2'b11, "memory load");
    chk(nad, {hwp, 1'b0, pab}, "memory address");
    apb(1'b1, 12'h000, 32'h0);
    resp(16'h5678, 1'b1);
    stop_test();
  end

  initial begin
    #50000;
    n_errors = n_errors + 1;
    stop_test();
  end
endmodule

// ===== test/psmc_pin_model.sv
/*
  Model of what hangs on the two sense pins: a resistor to ground, to
  battery or nothing on the address pin, and a contact on the switch pin.
  Assumes the block drives the two probe controls and reads both outputs.
*/
`timescale 1ns/1ps

module psmc_pin_model (
  input wire logic pclk, // clock of the idle pattern
  input wire logic [1:0] pin_cond, // 0 open, 1 to ground, 2 to battery
  input wire logic sw_closed, // switch contact closed
  input wire logic high_side_probe, // top switch closed
  input wire logic low_side_probe, // bottom switch closed
  output logic probe_comparator_out, // address pin comparator
  output logic switch_comparator_out // switch comparator
);
  logic junk = 1'b0;

  // With no switch closed nothing is sensed; a toggling level keeps a
  // design that samples outside its window from passing by luck.
  always @(posedge pclk) begin
    junk <= ~junk;
  end

  assign probe_comparator_out = low_side_probe ? (pin_cond == 2'd2) :
    high_side_probe ? (pin_cond == 2'd1) : junk;
  assign switch_comparator_out =
    (low_side_probe || high_side_probe) ? sw_closed : junk;
endmodule
